// ### rtl/stby_consts.svh
// constants of the standby ram retention controller
`ifndef STBY_CONSTS_SVH
`define STBY_CONSTS_SVH
`define RET_BYTES        8192
`define RET_ADDR_W       13
`define RAM_DATA_W       8
`define LVD_HOLD_CYCLES  16'h0010
`define LP_DET_EDGES     4'h8
`define LP_LOSS_CYCLES   16'h0100
`define RD_BLANK         8'h00
`endif

// ### rtl/stby_pkg.sv
// types of the standby ram retention controller
package stby_pkg;
  typedef enum logic [1:0] {SUPPLY_CORE, SUPPLY_STANDBY} supply_sel_t;
  typedef enum {ST_STANDBY, ST_FROZEN_CORE, ST_ACTIVE} ret_state_t;
endpackage : stby_pkg

// ### rtl/ram_gate_if.sv
// carrier between the controller and its isolation stage
`include "stby_consts.svh"
interface ram_gate_if;
  logic                       open;
  logic                       req;
  logic                       we;
  logic [`RET_ADDR_W-1:0]     addr;
  logic [`RAM_DATA_W-1:0]     wdata;
  modport ctrl (output open, req, we, addr, wdata);
  modport gate (input open, req, we, addr, wdata);
endinterface : ram_gate_if

// ### rtl/ram_isolation.sv
// isolation stage between core strobes and the retained array
`include "stby_consts.svh"
module ram_isolation (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  ram_gate_if.gate                    gi,
  output logic                        arr_en_r,
  output logic                        arr_we_r,
  output logic [`RET_ADDR_W-1:0]      arr_addr_r,
  output logic [`RAM_DATA_W-1:0]      arr_wdata_r
);
  // strobes reach the array only while the gate is open
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      arr_en_r    <= 1'b0;
      arr_we_r    <= 1'b0;
      arr_addr_r  <= '0;
      arr_wdata_r <= '0;
    end else begin
      arr_en_r    <= gi.open & gi.req;        // [R7]
      arr_we_r    <= gi.open & gi.req & gi.we; // [R7] [R14]
      arr_addr_r  <= gi.addr;
      arr_wdata_r <= gi.wdata;
    end
  end
endmodule : ram_isolation

// ### rtl/stby_ram_ctrl.sv
// standby ram retention controller
// How it works
// R1 - entering reset disables the retained ram and freezes its interface
// R2 - clearing standby_ram_enable freezes the interface once it has passed the two-stage synchroniser, except while core_rail_dip is set
// R3 - a reset event moves the ram supply to the standby rail
// R4 - interface stays frozen until software sets enable after power-on
// R5 - core rail below standby reference keeps ram frozen whatever enable says
// R6 - a dip with enable set never triggers standby; ram stays accessible
// R7 - isolation stage blocks core strobes during supply collapse
// R8 - retained region is a fixed 8 kbyte portion kept powered in standby
// R9 - low voltage detector holds reset until core rail is above about one volt
// R10 - outside circuitry holds reset pin low until supply is stable
// R11 - outside circuitry keeps reset pin steadily low during power-off
// R12 - after internal reset ends, frozen ram supply goes back to the core rail
// R13 - rtc counts in standby only on the low-power oscillator
// R14 - frozen interface returns no valid read data and ignores writes
// R15 - rtc takes the low-power oscillator once detected unless software disables it
`include "stby_consts.svh"
module stby_ram_ctrl
  import stby_pkg::*;
#(
  parameter int ADDR_W = `RET_ADDR_W,
  parameter int DATA_W = `RAM_DATA_W
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic                reset_input_pin_b,
  input  wire logic                core_rail_ok,
  input  wire logic                core_rail_above_ref,
  input  wire logic                core_rail_dip,
  input  wire logic                standby_ram_enable,
  input  wire logic                lp_osc_clk,
  input  wire logic                lp_osc_sw_disable,
  input  wire logic                ram_req,
  input  wire logic                ram_we,
  input  wire logic [ADDR_W-1:0]   ram_addr,
  input  wire logic [DATA_W-1:0]   ram_wdata,
  input  wire logic [DATA_W-1:0]   arr_rdata,
  output logic                     internal_reset_r,
  output logic                     ram_frozen_r,
  output logic                     supply_on_standby_r,
  output logic [DATA_W-1:0]        ram_rdata_r,
  output logic                     ram_rvalid_r,
  output logic                     rtc_on_lp_osc_r,
  output logic                     rtc_count_en_r,
  output logic                     arr_en_r,
  output logic                     arr_we_r,
  output logic [ADDR_W-1:0]        arr_addr_r,
  output logic [DATA_W-1:0]        arr_wdata_r
);

  // two-stage synchronisers for pins and analog comparators
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic       rst_pin_s;
  logic       rail_ok_s;
  logic       above_ref_s;
  logic       dip_s;
  logic       enable_s;
  logic       lp_clk_s;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {reset_input_pin_b, core_rail_ok, core_rail_above_ref,
                  core_rail_dip, standby_ram_enable, lp_osc_clk};
      sync2_r <= sync1_r;
    end
  end

  assign {rst_pin_s, rail_ok_s, above_ref_s, dip_s, enable_s, lp_clk_s} = sync2_r;

  // low voltage detector hold: reset until rail is good for a settle count
  logic [15:0] lvd_cnt_r;
  logic        lvd_hold;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lvd_cnt_r <= '0;
    end else if (!rail_ok_s) begin
      lvd_cnt_r <= '0;                          // [R9]
    end else if (lvd_cnt_r != `LVD_HOLD_CYCLES) begin
      lvd_cnt_r <= lvd_cnt_r + 16'h0001;
    end
  end

  assign lvd_hold = (lvd_cnt_r != `LVD_HOLD_CYCLES); // [R9]

  // internal reset: pin low (held steady by outside circuitry) or detector hold
  logic reset_nxt;
  assign reset_nxt = !rst_pin_s || lvd_hold; // [R9] [R10] [R11]

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      internal_reset_r <= 1'b1;
    end else begin
      internal_reset_r <= reset_nxt;
    end
  end

  // retention sequencing state
  ret_state_t state_r;
  ret_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_STANDBY: begin
        if (!internal_reset_r) begin
          state_nxt = ST_FROZEN_CORE;             // [R12]
        end
      end
      ST_FROZEN_CORE: begin
        if (internal_reset_r) begin
          state_nxt = ST_STANDBY;                 // [R3]
        end else if (enable_s && above_ref_s) begin
          state_nxt = ST_ACTIVE;                  // [R4] [R5]
        end
      end
      ST_ACTIVE: begin
        if (internal_reset_r) begin
          state_nxt = ST_STANDBY;                 // [R1] [R3]
        end else if (!enable_s && !dip_s) begin
          state_nxt = ST_FROZEN_CORE;             // [R2] [R6]
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // frozen in every state but active, and at once while reset is pending
  function automatic logic frozen_for(input ret_state_t s, input logic rst);
    return (s != ST_ACTIVE) || rst;
  endfunction : frozen_for

  // standby rail only in standby, and at once while reset is pending
  function automatic logic standby_for(input ret_state_t s, input logic rst);
    return (s == ST_STANDBY) || rst;
  endfunction : standby_for

  // freeze and supply select, registered from next state
  // reset is folded in so that freeze and rail switch land on the same edge
  // as internal reset; waiting for the state machine would leave one open cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ram_frozen_r        <= 1'b1;
      supply_on_standby_r <= 1'b1;
    end else begin
      ram_frozen_r        <= frozen_for(state_nxt, reset_nxt);  // [R1] [R2] [R5]
      supply_on_standby_r <= standby_for(state_nxt, reset_nxt); // [R3] [R12]
    end
  end

  // isolation stage towards the retained 8 kbyte array
  ram_gate_if gi ();
  assign gi.open  = !ram_frozen_r;              // [R7]
  assign gi.req   = ram_req;
  assign gi.we    = ram_we;
  assign gi.addr  = ram_addr[`RET_ADDR_W-1:0];  // [R8]
  assign gi.wdata = ram_wdata[`RAM_DATA_W-1:0];

  ram_isolation u_iso (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .gi          (gi),
    .arr_en_r    (arr_en_r),
    .arr_we_r    (arr_we_r),
    .arr_addr_r  (arr_addr_r),
    .arr_wdata_r (arr_wdata_r)
  );

  // read return: blank and not valid while frozen
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ram_rdata_r  <= `RD_BLANK;
      ram_rvalid_r <= 1'b0;
    end else if (arr_en_r && !arr_we_r && !ram_frozen_r) begin
      ram_rdata_r  <= arr_rdata;
      ram_rvalid_r <= 1'b1;
    end else begin
      ram_rdata_r  <= `RD_BLANK;                // [R14]
      ram_rvalid_r <= 1'b0;                     // [R14]
    end
  end

  // low-power oscillator detection by counting its edges
  logic        lp_prev_r;
  logic [3:0]  lp_edges_r;
  logic [15:0] lp_idle_r;
  logic        lp_rise;
  assign lp_rise = lp_clk_s && !lp_prev_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lp_prev_r  <= 1'b0;
      lp_edges_r <= '0;
      lp_idle_r  <= '0;
    end else begin
      lp_prev_r <= lp_clk_s;
      if (lp_rise) begin
        lp_idle_r <= '0;
        if (lp_edges_r != `LP_DET_EDGES) begin
          lp_edges_r <= lp_edges_r + 4'h1;
        end
      end else if (lp_idle_r != `LP_LOSS_CYCLES) begin
        lp_idle_r <= lp_idle_r + 16'h0001;
      end else begin
        lp_edges_r <= '0;
      end
    end
  end

  // rtc reference: keep low-power oscillator once seen, unless disabled
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rtc_on_lp_osc_r <= 1'b0;
    end else if (lp_osc_sw_disable) begin
      rtc_on_lp_osc_r <= 1'b0;                  // [R15]
    end else if (lp_edges_r == `LP_DET_EDGES) begin
      rtc_on_lp_osc_r <= 1'b1;                  // [R15]
    end
  end

  // rtc counting: main oscillator stops with core supply in standby
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rtc_count_en_r <= 1'b0;
    end else begin
      rtc_count_en_r <= rtc_on_lp_osc_r || !supply_on_standby_r; // [R13]
    end
  end

endmodule : stby_ram_ctrl

// ### dv/stby_ram_ctrl_sva.sv
// concurrent checks on the retention controller ports
module stby_ram_ctrl_sva (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reset_input_pin_b,
  input wire logic core_rail_above_ref,
  input wire logic core_rail_dip,
  input wire logic standby_ram_enable,
  input wire logic ram_req,
  input wire logic ram_we,
  input wire logic internal_reset_r,
  input wire logic ram_frozen_r,
  input wire logic supply_on_standby_r,
  input wire logic ram_rvalid_r,
  input wire logic arr_en_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // enable drop outside any dip
  sequence s_en_drop;
    $fell(standby_ram_enable) && !core_rail_dip && reset_input_pin_b;
  endsequence
  sequence s_rail_low;
    (!core_rail_above_ref)[*3] ##0 ram_frozen_r;
  endsequence
  sequence s_en_held;
    (standby_ram_enable && reset_input_pin_b)[*4] ##0 !ram_frozen_r;
  endsequence
  property p_frz_gate; $past(ram_frozen_r) |-> !arr_en_r; endproperty
  property p_frz_rd; $past(ram_frozen_r) |=> !ram_rvalid_r; endproperty
  property p_rst_frz; internal_reset_r |-> ram_frozen_r; endproperty
  property p_rst_stby; internal_reset_r |-> supply_on_standby_r; endproperty
  property p_back_core; $fell(internal_reset_r) |-> ##[0:1] !supply_on_standby_r; endproperty
  property p_en_drop; s_en_drop |-> ##[1:4] ram_frozen_r; endproperty
  property p_rail_low; s_rail_low |=> ram_frozen_r; endproperty
  property p_no_spur; s_en_held |=> !ram_frozen_r; endproperty
  a_frz_gate: assert property (p_frz_gate) else $error("array strobe while frozen");
  a_frz_rd: assert property (p_frz_rd) else $error("read data while frozen");
  a_rst_frz: assert property (p_rst_frz) else $error("open during reset");
  a_rst_stby: assert property (p_rst_stby) else $error("core rail during reset");
  a_back_core: assert property (p_back_core) else $error("supply not back");
  a_en_drop: assert property (p_en_drop) else $error("no freeze on clear");
  a_rail_low: assert property (p_rail_low) else $error("open below ref");
  a_no_spur: assert property (p_no_spur) else $error("spurious freeze");
endmodule : stby_ram_ctrl_sva

// ### dv/stby_partner.sv
// far side: reset circuitry, supply rails and low-power oscillator
module stby_partner (
  input  wire logic pwr_up,
  input  wire logic sag,
  output logic      reset_input_pin_b,
  output logic      core_rail_ok,
  output logic      core_rail_above_ref,
  output logic      lp_osc_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic up_r;
  // free-running oscillator
  always #100 lp_osc_clk = ~lp_osc_clk;
  // rails ramp, pin held low around every ramp
  initial begin
    lp_osc_clk = 1'b0;
    reset_input_pin_b = 1'b0;
    core_rail_ok = 1'b0;
    up_r = 1'b0;
  end
  always @(pwr_up) begin
    if (pwr_up) begin
      core_rail_ok = 1'b1;
      #100 up_r = 1'b1;
      #1000 reset_input_pin_b = 1'b1; // released only once stable
    end else begin
      reset_input_pin_b = 1'b0; // steady low before rails fall
      #200 up_r = 1'b0;
      #100 core_rail_ok = 1'b0;
    end
  end
  assign core_rail_above_ref = up_r && !sag;
endmodule : stby_partner

// ### dv/stby_ram_ctrl_tb.sv
// self-checking bench of the retention controller
`include "stby_consts.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module stby_ram_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst_b = 0, pwr_up = 0, sag = 0, core_rail_dip = 0;
  logic standby_ram_enable = 0, lp_osc_sw_disable = 0, ram_req = 0, ram_we = 0;
  logic reset_input_pin_b, core_rail_ok, core_rail_above_ref, lp_osc_clk;
  logic internal_reset_r, ram_frozen_r, supply_on_standby_r, ram_rvalid_r;
  logic rtc_on_lp_osc_r, rtc_count_en_r, arr_en_r, arr_we_r;
  logic [`RET_ADDR_W-1:0] ram_addr = '0, arr_addr_r;
  logic [7:0] ram_wdata = '0, arr_rdata, ram_rdata_r, arr_wdata_r;
  logic [7:0] mem [`RET_BYTES], shadow [`RET_BYTES], exp_q [$];
  int errors = 0, comparisons = 0;
  logic [31:0] seed = 32'h00002d31;
  stby_ram_ctrl u_stby_ram_ctrl (.*);
  stby_partner u_stby_partner (.*);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  // one request per call; caller releases
  task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d, input bit open);
    @(posedge clk_sys);
    ram_req <= 1'b1;
    ram_we <= w;
    ram_addr <= a;
    ram_wdata <= d;
    if (open && w) shadow[a] = d;
    if (open && !w) exp_q.push_back(shadow[a]);
  endtask : acc
  task automatic idle(input int n);
    @(posedge clk_sys);
    ram_req <= 1'b0;
    repeat (n) @(negedge clk_sys);
  endtask : idle
  task automatic power(input bit on);
    @(posedge clk_sys);
    pwr_up <= on;
    if (!on) standby_ram_enable <= 1'b0;
    for (int i = 0; i < 200 && internal_reset_r !== !on; i++) @(negedge clk_sys);
    // after power-off let the rails finish falling before the next ramp
    repeat (on ? 2 : 20) @(negedge clk_sys);
  endtask : power
  always #10 clk_sys = ~clk_sys;
  // array model behind the isolation stage
  assign arr_rdata = mem[arr_addr_r];
  always @(posedge clk_sys) if (arr_en_r && arr_we_r) mem[arr_addr_r] <= arr_wdata_r;
  // pair each read return with the oldest expectation
  always @(posedge clk_sys) begin : mon
    logic [7:0] e;
    if (ram_rvalid_r) begin
      e = exp_q.size() ? exp_q.pop_front() : 8'hxx;
      `CHK("rdata", e, ram_rdata_r)
    end
  end
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
  initial begin
    for (int i = 0; i < `RET_BYTES; i++) begin
      mem[i] = 8'(xs());
      shadow[i] = mem[i];
    end
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      power(1);
      `CHK("supply", 1'b0, supply_on_standby_r)
      `CHK("frozen", 1'b1, ram_frozen_r)
      acc(1, 13'h0005, 8'h3c, 0);
      acc(0, 13'h0005, 8'h00, 0);
      idle(2);
      sag <= 1'b1;
      standby_ram_enable <= 1'b1;
      idle(8);
      `CHK("rail low", 1'b1, ram_frozen_r)
      sag <= 1'b0;
      idle(8);
      `CHK("enabled", 1'b0, ram_frozen_r)
      for (int i = 0; i < 40; i++)
        acc(i > 20, i[0] ? 13'h1fff : i[1] ? 13'h0000 : 13'(xs()), 8'(xs()), 1);
      acc(0, 13'h0005, 8'h00, 1);
      acc(0, 13'h1fff, 8'h00, 1);
      sag <= 1'b1;
      core_rail_dip <= 1'b1;
      idle(4);
      acc(0, 13'h0000, 8'h00, 1);
      idle(4);
      `CHK("dip", 1'b0, ram_frozen_r)
      sag <= 1'b0;
      core_rail_dip <= 1'b0;
      standby_ram_enable <= 1'b0;
      idle(4);
      acc(1, 13'h0005, 8'h77, 0);
      acc(0, 13'h0005, 8'h00, 0);
      idle(4);
      `CHK("cleared", 1'b1, ram_frozen_r)
      `CHK("rtc lp", ~lp_osc_sw_disable, rtc_on_lp_osc_r)
      power(0);
      `CHK("reset frz", 1'b1, ram_frozen_r)
      `CHK("standby", 1'b1, supply_on_standby_r)
      `CHK("rtc count", ~lp_osc_sw_disable, rtc_count_en_r)
      lp_osc_sw_disable <= 1'b1;
    end
    `CHK("queue", 0, exp_q.size())
    give_verdict();
  end
endmodule : stby_ram_ctrl_tb
bind stby_ram_ctrl stby_ram_ctrl_sva u_stby_ram_ctrl_sva (.*);
